/* File: alu_ops_map.vh */
// Constants for the byte instruction execution datapath.
`ifndef ALU_OPS_MAP_VH
`define ALU_OPS_MAP_VH
`define OP_NONE          3'h0
`define OP_MUL_LIT       3'h1
`define OP_MUL_REG       3'h2
`define OP_SWAP          3'h3
`define OP_SUB_BORROW    3'h4
`define OP_JUMP          3'h5
`define INDEXED_LIMIT    8'h5f
`define ACCESS_HIGH_BASE 12'hf00
`define ACCESS_SPLIT     8'h80
`define FLAG_C           0
`define FLAG_DC          1
`define FLAG_Z           2
`define FLAG_OV          3
`define FLAG_N           4
`define STATUS_RESET     5'h00
`endif

/* File: quarter_phase_gen.v */
// Quarter-phase sequencer for the instruction cycle.
module quarter_phase_gen (
    input  wire       clk_i,    // Core clock
    input  wire       rst_n_i,  // Synchronised reset, active low
    output reg  [3:0] phase_o   // One-hot quarter phases
);
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_o <= 4'h1;
        else
            phase_o <= {phase_o[2:0], phase_o[3]};
    end
endmodule

/* File: byte_alu_instruction_ops.v */
// Execution datapath for multiply, swap, subtract-borrow and jump.
`include "alu_ops_map.vh"
module byte_alu_instruction_ops (
    input  wire        clk_i,          // Core clock, 100 MHz
    input  wire        nrst_i,         // Asynchronous reset, active low
    input  wire        start_i,        // Start instruction at next Q1
    input  wire [2:0]  op_i,           // Operation select
    input  wire [7:0]  file_addr_i,    // File address field
    input  wire        dest_sel_i,     // Destination select bit
    input  wire        access_sel_i,   // Access select bit
    input  wire        ext_set_i,      // Extended instruction set enable
    input  wire [7:0]  literal_i,      // Literal k<7:0>
    input  wire [11:0] literal_hi_i,   // Literal k<19:8>
    input  wire [3:0]  bank_select_register_i, // Bank select value
    input  wire [11:0] index_base_i,   // Index base for offset mode
    input  wire [7:0]  file_rdata_i,   // Data read from file address
    output reg  [11:0] file_addr_o,    // Resolved data address
    output reg         file_rd_o,      // File read strobe
    output reg         file_we_o,      // File write strobe
    output reg  [7:0]  file_wdata_o,   // File write data
    output reg  [7:0]  accumulator_o,  // Accumulator
    output reg  [7:0]  product_high_byte_o, // Product high byte
    output reg  [7:0]  product_low_byte_o,  // Product low byte
    output reg  [4:0]  status_o,       // N OV Z DC C flags
    output reg  [20:0] pc_o,           // Program counter
    output reg  [3:0]  phase_o,        // Quarter phase, one-hot
    output reg         busy_o          // Instruction in progress
);
    localparam S_IDLE = 3'b001;
    localparam S_EXEC = 3'b010;
    localparam S_NOP  = 3'b100;

    reg        rst_meta;
    reg        rst_n;
    reg [2:0]  state;
    reg [2:0]  op;
    reg        dest;
    reg [15:0] product_q;
    reg [7:0]  result_q;
    reg [4:0]  status_q;
    reg [7:0]  operand;
    reg [7:0]  lit_lo;
    reg [15:0] product;
    reg [7:0]  result;
    reg [4:0]  next_status;
    wire [3:0] q;
    wire       quarter_phase_one   = q[0];
    wire       quarter_phase_two   = q[1];
    wire       quarter_phase_three = q[2];
    wire       quarter_phase_four  = q[3];
    wire [8:0] diff;
    wire [4:0] diff_lo;

    // Resolves the data address from the operand fields.
    function [11:0] resolve_addr;
        input [7:0]  f;
        input        a;
        input        e;
        input [3:0]  bank;
        input [11:0] base;
        begin
            if (!a && e && f <= `INDEXED_LIMIT)
                resolve_addr = base + {4'h0, f};
            else if (!a)
                resolve_addr = (f < `ACCESS_SPLIT) ? {4'h0, f}
                               : (`ACCESS_HIGH_BASE | {4'h0, f});
            else
                resolve_addr = {bank, f};
        end
    endfunction

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    quarter_phase_gen u_phase (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .phase_o (q)
    );

    // Borrow in is the inverted carry, so carry in is the carry flag.
    assign diff    = {1'b0, operand} + {1'b0, ~accumulator_o}
                     + {8'h00, status_o[`FLAG_C]};
    assign diff_lo = {1'b0, operand[3:0]} + {1'b0, ~accumulator_o[3:0]}
                     + {4'h0, status_o[`FLAG_C]};

    always @*
    begin
        product     = 16'h0000;
        result      = 8'h00;
        next_status = status_o;
        case (op)
        `OP_MUL_LIT:
            product = {8'h00, accumulator_o} * {8'h00, lit_lo};
        `OP_MUL_REG:
            product = {8'h00, accumulator_o} * {8'h00, operand};
        `OP_SWAP:
            result = {operand[3:0], operand[7:4]};
        `OP_SUB_BORROW:
        begin
            result = diff[7:0];
            next_status[`FLAG_C]  = diff[8];
            next_status[`FLAG_DC] = diff_lo[4];
            next_status[`FLAG_Z]  = (diff[7:0] == 8'h00);
            next_status[`FLAG_N]  = diff[7];
            next_status[`FLAG_OV] = (operand[7] != accumulator_o[7])
                                    && (diff[7] != operand[7]);
        end
        default:
            result = 8'h00;
        endcase
    end

    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            op <= `OP_NONE;
            dest <= 1'b0;
            product_q <= 16'h0000;
            result_q <= 8'h00;
            status_q <= `STATUS_RESET;
            operand <= 8'h00;
            lit_lo <= 8'h00;
            file_addr_o <= 12'h000;
            file_rd_o <= 1'b0;
            file_we_o <= 1'b0;
            file_wdata_o <= 8'h00;
            accumulator_o <= 8'h00;
            product_high_byte_o <= 8'h00;
            product_low_byte_o <= 8'h00;
            status_o <= `STATUS_RESET;
            pc_o <= 21'h000000;
            phase_o <= 4'h1;
            busy_o <= 1'b0;
        end
        else
        begin
            phase_o   <= q;
            file_rd_o <= 1'b0;
            file_we_o <= 1'b0;
            case (state)
            S_IDLE:
            begin
                // Decode happens in the first quarter of a cycle.
                if (start_i && quarter_phase_one)
                begin
                    op      <= op_i;
                    dest    <= dest_sel_i;
                    busy_o  <= 1'b1;
                    state   <= S_EXEC;
                    file_addr_o <= resolve_addr(file_addr_i, access_sel_i,
                        ext_set_i, bank_select_register_i, index_base_i);
                    file_rd_o <= 1'b1;
                end
            end
            S_EXEC:
            begin
                if (quarter_phase_two)
                begin
                    operand <= file_rdata_i;
                    lit_lo  <= literal_i;
                end
                // The third quarter freezes the results, so the fourth
                // quarter writes back values that no longer move, except a jump, which loads pc_o from literal_hi_i as it stands then.
                if (quarter_phase_three)
                begin
                    product_q <= product;
                    result_q  <= result;
                    status_q  <= next_status;
                end
                if (quarter_phase_four)
                begin
                    state  <= S_IDLE;
                    busy_o <= 1'b0;
                    case (op)
                    `OP_MUL_LIT, `OP_MUL_REG:
                    begin
                        // Flags and accumulator are left alone here.
                        product_high_byte_o <= product_q[15:8];
                        product_low_byte_o  <= product_q[7:0];
                    end
                    `OP_SWAP, `OP_SUB_BORROW:
                    begin
                        status_o <= status_q;
                        if (dest)
                        begin
                            file_we_o    <= 1'b1;
                            file_wdata_o <= result_q;
                        end
                        else
                            accumulator_o <= result_q;
                    end
                    `OP_JUMP:
                    begin
                        pc_o   <= {literal_hi_i, lit_lo, 1'b0};
                        state  <= S_NOP;
                        busy_o <= 1'b1;
                    end
                    default:
                        state <= S_IDLE;
                    endcase
                end
            end
            S_NOP:
            begin
                // Second jump cycle does nothing until quarter four, which clears busy and returns to idle.
                if (quarter_phase_four)
                begin
                    state  <= S_IDLE;
                    busy_o <= 1'b0;
                end
            end
            default:
                state <= S_IDLE;
            endcase
        end
    end

endmodule

/* File: byte_alu_checker.sv */
// Concurrent checks on the byte instruction datapath ports.
`include "alu_ops_map.vh"
module byte_alu_checker (
    input logic        clk_i, nrst_i, dest_sel_i, access_sel_i, ext_set_i,
    input logic        file_we_o, busy_o,
    input logic [2:0]  op_i,
    input logic [3:0]  bank_select_register_i, phase_o,
    input logic [7:0]  file_addr_i, accumulator_o,
    input logic [11:0] index_base_i, file_addr_o,
    input logic [4:0]  status_o,
    input logic [20:0] pc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    chk_phase_onehot: assert property ($onehot(phase_o))
        else $error("quarter phase not one-hot");
    chk_phase_order: assert property (phase_o[1] |=> phase_o[2])
        else $error("quarter two not followed by quarter three");
    chk_jump_cycles: assert property ($rose(busy_o) && op_i == `OP_JUMP
        |-> busy_o[*7] ##1 !busy_o) else $error("jump length wrong");
    chk_alu_cycles: assert property ($rose(busy_o) && op_i != `OP_JUMP
        |-> busy_o[*3] ##1 !busy_o) else $error("single cycle length wrong");
    chk_flags_kept: assert property ($rose(busy_o) && op_i inside
        {`OP_MUL_LIT, `OP_MUL_REG, `OP_SWAP} |-> $stable(status_o)[*4])
        else $error("flags changed by multiply or swap");
    chk_acc_kept: assert property ($rose(busy_o) && op_i == `OP_MUL_LIT
        |-> $stable(accumulator_o)[*4]) else $error("accumulator changed");
    chk_dest_file: assert property ($rose(busy_o) && op_i == `OP_SWAP
        |-> ##3 file_we_o == $past(dest_sel_i, 3))
        else $error("write strobe disagrees with destination bit");
    chk_bank_addr: assert property ($rose(busy_o) && access_sel_i && op_i
        inside {`OP_MUL_REG, `OP_SWAP, `OP_SUB_BORROW}
        |-> file_addr_o == {bank_select_register_i, file_addr_i})
        else $error("banked address wrong");
    chk_index_addr: assert property ($rose(busy_o) && !access_sel_i
        && ext_set_i && file_addr_i <= `INDEXED_LIMIT && op_i inside
        {`OP_MUL_REG, `OP_SWAP, `OP_SUB_BORROW}
        |-> file_addr_o == index_base_i + {4'h0, file_addr_i})
        else $error("indexed address wrong");
    cov_jump: cover property ($rose(busy_o) && op_i == `OP_JUMP);
    cov_sub: cover property ($rose(busy_o) && op_i == `OP_SUB_BORROW);
    cov_write: cover property ($rose(file_we_o));
endmodule
bind byte_alu_instruction_ops byte_alu_checker chk_u (.clk_i, .nrst_i,
    .dest_sel_i, .access_sel_i, .ext_set_i, .file_we_o, .busy_o, .op_i,
    .bank_select_register_i, .phase_o, .file_addr_i, .accumulator_o,
    .index_base_i, .file_addr_o, .status_o, .pc_o);

/* File: byte_alu_instruction_ops_bench.sv */
// Self-checking bench for the byte instruction datapath.
`include "alu_ops_map.vh"
module byte_alu_instruction_ops_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'h0, nrst_i = 1'h0, start_i = 1'h0;
    logic        dest_sel_i = 1'h0, access_sel_i = 1'h0, ext_set_i = 1'h0;
    logic [2:0]  op_i = 3'h0;
    logic [7:0]  file_addr_i = 8'h00, literal_i = 8'h00, file_rdata_i = 8'h00;
    logic [11:0] literal_hi_i = 12'h000, index_base_i = 12'h200;
    logic [3:0]  bank_select_register_i = 4'h3;
    wire  [11:0] file_addr_o;
    wire         file_rd_o, file_we_o, busy_o;
    wire  [7:0]  file_wdata_o, accumulator_o;
    wire  [7:0]  product_high_byte_o, product_low_byte_o;
    wire  [4:0]  status_o;
    wire  [20:0] pc_o;
    wire  [3:0]  phase_o;
    int          fail_count = 0, cmp_count = 0;
    logic [11:0] addr_seen;
    logic        we_seen;
    logic [7:0]  wdata_seen;
    byte_alu_instruction_ops dut_u (.clk_i, .nrst_i, .start_i, .op_i,
        .file_addr_i, .dest_sel_i, .access_sel_i, .ext_set_i, .literal_i,
        .literal_hi_i, .bank_select_register_i, .index_base_i, .file_rdata_i,
        .file_addr_o, .file_rd_o, .file_we_o, .file_wdata_o, .accumulator_o,
        .product_high_byte_o, .product_low_byte_o, .status_o, .pc_o,
        .phase_o, .busy_o);
    initial
        forever #5 clk_i = ~clk_i;
    task automatic compare(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Start is held until the clock after busy shows, since it is only taken in quarter one.
    task automatic run_op(input logic [2:0] op, input logic [7:0] f, k, rd,
                          input logic d, a, e, input logic [11:0] hi);
        int n;
        n = 0;
        we_seen = 1'h0;
        @(posedge clk_i);
        {op_i, file_addr_i, literal_i, file_rdata_i, dest_sel_i, access_sel_i,
         ext_set_i, literal_hi_i, start_i} <= {op, f, k, rd, d, a, e, hi, 1'h1};
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end while (busy_o !== 1'h1 && n < 20);
        addr_seen = file_addr_o;
        compare(file_rd_o, 1'h1);
        @(posedge clk_i);
        start_i <= 1'h0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
            if (file_we_o === 1'h1)
            begin
                we_seen = 1'h1;
                wdata_seen = file_wdata_o;
            end
        end while (busy_o !== 1'h0 && n < 40);
        compare(n < 40, 1'h1);
    endtask
    task automatic t_swap_acc;
        run_op(`OP_SWAP, 8'h90, 8'h00, 8'h35, 1'h0, 1'h0, 1'h0, 12'h000);
        compare(accumulator_o, 8'h53);
        compare(we_seen, 1'h0);
        compare(addr_seen, 12'hf90);
    endtask
    task automatic t_mul_lit;
        run_op(`OP_MUL_LIT, 8'h00, 8'hc4, 8'h00, 1'h0, 1'h0, 1'h0, 12'h000);
        compare({product_high_byte_o, product_low_byte_o}, 16'h3f8c);
        compare(accumulator_o, 8'h53);
        compare(status_o, 5'h12);
    endtask
    task automatic t_mul_reg;
        run_op(`OP_MUL_REG, 8'h10, 8'h00, 8'hb5, 1'h0, 1'h1, 1'h0, 12'h000);
        compare({product_high_byte_o, product_low_byte_o}, 16'h3aaf);
        compare(addr_seen, 12'h310);
    endtask
    task automatic t_sub;
        run_op(`OP_SUB_BORROW, 8'h5f, 8'h00, 8'h19, 1'h1, 1'h0, 1'h1, 12'h000);
        compare({we_seen, wdata_seen}, 9'h1c5);
        compare(status_o, 5'h12);
        compare(addr_seen, 12'h25f);
    endtask
    task automatic t_swap_file;
        run_op(`OP_SWAP, 8'h60, 8'h00, 8'hc5, 1'h1, 1'h0, 1'h1, 12'h000);
        compare({we_seen, wdata_seen}, 9'h15c);
        compare({status_o, accumulator_o}, 13'h1253);
        compare(addr_seen, 12'h060);
    endtask
    task automatic t_jump;
        run_op(`OP_JUMP, 8'h00, 8'h45, 8'h00, 1'h0, 1'h0, 1'h0, 12'h123);
        compare(pc_o, 21'h2468a);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'h1;
        t_swap_acc();
        t_sub();
        t_mul_lit();
        t_mul_reg();
        t_swap_file();
        t_jump();
        finish_test();
    end
    initial
    begin
        #20000;
        fail_count++;
        finish_test();
    end
endmodule
